// [src/scp_dev_end.sv]
// Device end of the serial command ports, with the shared serial building blocks.
// Assumes line inputs are asynchronous and the host end follows the link handshake.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Three-stage line synchroniser
// ----------------------------------------------------------------
module scp_sync3 (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_reg, s2_reg, s3_reg, level_reg;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_reg <= scp_pkg::LINE_IDLE;
      s2_reg <= scp_pkg::LINE_IDLE;
      s3_reg <= scp_pkg::LINE_IDLE;
      level_reg <= scp_pkg::LINE_IDLE;
    end
    else
    begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end
  end
  assign o_level = level_reg;
endmodule

// ----------------------------------------------------------------
// Character transmitter
// ----------------------------------------------------------------
module scp_uart_tx (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [15:0] i_div,
  input wire logic [7:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic o_line
);
  logic idle_reg, line_reg;
  logic [8:0] sh_reg;
  logic [3:0] bits_reg;
  logic [15:0] cnt_reg;
  wire logic tick = !idle_reg && (cnt_reg == 16'h0000);
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      idle_reg <= 1'b1;
      line_reg <= scp_pkg::LINE_IDLE;
      sh_reg <= 9'h1FF;
      bits_reg <= 4'h0;
      cnt_reg <= 16'h0000;
    end
    else if (idle_reg)
    begin
      if (i_valid)
      begin
        idle_reg <= 1'b0;
        line_reg <= 1'b0;
        sh_reg <= {1'b1, i_data};
        bits_reg <= 4'h1;
        cnt_reg <= i_div - 16'h0001;
      end
    end
    else if (!tick)
      cnt_reg <= cnt_reg - 16'h0001;
    else
    begin
      cnt_reg <= i_div - 16'h0001;
      bits_reg <= bits_reg + 4'h1;
      if (bits_reg == scp_pkg::TX_DONE_IDX)
        idle_reg <= 1'b1;
      else
      begin
        line_reg <= sh_reg[0];
        sh_reg <= {1'b1, sh_reg[8:1]};
      end
    end
  end
  assign o_ready = idle_reg;
  assign o_line = line_reg;
endmodule

// ----------------------------------------------------------------
// Character receiver
// ----------------------------------------------------------------
module scp_uart_rx (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [15:0] i_div,
  input wire logic i_line,
  output logic [7:0] o_data,
  output logic o_valid,
  output logic o_busy
);
  logic busy_reg, valid_reg;
  logic [15:0] cnt_reg;
  logic [3:0] bits_reg;
  logic [7:0] sh_reg, data_reg;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      busy_reg <= 1'b0;
      valid_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      bits_reg <= 4'h0;
      sh_reg <= 8'h00;
      data_reg <= 8'h00;
    end
    else
    begin
      valid_reg <= 1'b0;
      if (!busy_reg)
      begin
        if (!i_line)
        begin
          busy_reg <= 1'b1;
          cnt_reg <= {1'b0, i_div[15:1]};
          bits_reg <= 4'h0;
        end
      end
      else if (cnt_reg != 16'h0000)
        cnt_reg <= cnt_reg - 16'h0001;
      else
      begin
        cnt_reg <= i_div - 16'h0001;
        bits_reg <= bits_reg + 4'h1;
        if (bits_reg == 4'h0 && i_line)
          busy_reg <= 1'b0;
        else if (bits_reg == scp_pkg::STOP_BIT_IDX)
        begin
          busy_reg <= 1'b0;
          valid_reg <= i_line;
          data_reg <= sh_reg;
        end
        else if (bits_reg != 4'h0)
          sh_reg <= {i_line, sh_reg[7:1]};
      end
    end
  end
  assign o_data = data_reg;
  assign o_valid = valid_reg;
  assign o_busy = busy_reg;
endmodule

// ----------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------
module scp_fifo #(
  parameter int WIDTH = scp_pkg::FIFO_WIDTH,
  parameter int DEPTH = scp_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  logic ready_reg;
  wire logic push = i_valid && ready_reg;
  wire logic pop = i_ready && (cnt_reg != '0);
  wire logic [AW:0] cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem[wr_reg] <= i_data;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b1;
    end
    else
    begin
      wr_reg <= push ? wr_reg + AW'(1) : wr_reg;
      rd_reg <= pop ? rd_reg + AW'(1) : rd_reg;
      cnt_reg <= cnt_next;
      ready_reg <= cnt_next != (AW + 1)'(DEPTH);
    end
  end
  assign o_ready = ready_reg;
  assign o_valid = cnt_reg != '0;
  assign o_data = mem[rd_reg];
endmodule

// ----------------------------------------------------------------
// Frame sender with request and clear handshake
// ----------------------------------------------------------------
module scp_framer (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clear_n,
  input wire logic [15:0] i_gap,
  input wire logic [8:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic o_line,
  output logic o_req_n,
  output logic o_busy
);
  scp_pkg::scp_frame_type state_reg, state_next;
  logic [15:0] gap_reg;
  logic req_n_reg;
  logic u_ready;
  wire logic last = i_data[scp_pkg::LAST_BIT_POS];
  wire logic special = scp_pkg::is_special(i_data[7:0]);
  wire logic in_req = state_reg == scp_pkg::FR_REQ;
  wire logic in_data = state_reg == scp_pkg::FR_DATA;
  wire logic in_esc = state_reg == scp_pkg::FR_ESC2;
  wire logic in_close = state_reg == scp_pkg::FR_CLOSE;
  // Once the opening flag is out, the clear input is no longer looked at.
  wire logic go = (in_req && !i_clear_n) || (in_data && i_valid) || in_esc || in_close;
  wire logic accept = go && u_ready;
  wire logic [7:0] esc_byte = i_data[7:0] ^ scp_pkg::HDLC_XOR;
  wire logic [7:0] data_byte = special ? scp_pkg::HDLC_ESC : i_data[7:0];
  wire logic [7:0] tx_byte = (in_req || in_close) ? scp_pkg::HDLC_FLAG :
                             (in_esc ? esc_byte : data_byte);
  assign o_ready = accept && ((in_data && !special) || in_esc);
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      scp_pkg::FR_IDLE:
        if (i_valid && gap_reg == 16'h0000)
          state_next = scp_pkg::FR_REQ;
      scp_pkg::FR_REQ:
        if (accept)
          state_next = scp_pkg::FR_DATA;
      scp_pkg::FR_DATA:
        if (accept)
          state_next = special ? scp_pkg::FR_ESC2 : (last ? scp_pkg::FR_CLOSE : scp_pkg::FR_DATA);
      scp_pkg::FR_ESC2:
        if (accept)
          state_next = last ? scp_pkg::FR_CLOSE : scp_pkg::FR_DATA;
      scp_pkg::FR_CLOSE:
        if (accept)
          state_next = scp_pkg::FR_DRAIN;
      scp_pkg::FR_DRAIN:
        if (u_ready)
          state_next = scp_pkg::FR_IDLE;
      default:
        state_next = scp_pkg::FR_IDLE;
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= scp_pkg::FR_IDLE;
      req_n_reg <= 1'b1;
      gap_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      req_n_reg <= state_next == scp_pkg::FR_IDLE;
      if (state_reg == scp_pkg::FR_DRAIN && u_ready)
        gap_reg <= i_gap;
      else if (gap_reg != 16'h0000)
        gap_reg <= gap_reg - 16'h0001;
    end
  end
  scp_uart_tx u_tx (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_div(scp_pkg::PKT_DIV),
    .i_data(tx_byte),
    .i_valid(go),
    .o_ready(u_ready),
    .o_line(o_line)
  );
  assign o_req_n = req_n_reg;
  assign o_busy = state_reg != scp_pkg::FR_IDLE;
endmodule

// ----------------------------------------------------------------
// Frame receiver
// ----------------------------------------------------------------
module scp_deframe (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [7:0] i_byte,
  input wire logic i_valid,
  output logic [7:0] o_data,
  output logic o_valid,
  output logic o_end
);
  logic esc_reg, open_reg, had_reg, valid_reg, end_reg;
  logic [7:0] data_reg;
  wire logic is_flag = i_byte == scp_pkg::HDLC_FLAG;
  wire logic is_esc = i_byte == scp_pkg::HDLC_ESC;
  wire logic [7:0] plain = esc_reg ? (i_byte ^ scp_pkg::HDLC_XOR) : i_byte;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {esc_reg, open_reg, had_reg, valid_reg, end_reg} <= 5'h00;
      data_reg <= 8'h00;
    end
    else
    begin
      valid_reg <= 1'b0;
      end_reg <= 1'b0;
      if (i_valid && is_flag)
      begin
        end_reg <= open_reg && had_reg;
        {open_reg, had_reg, esc_reg} <= 3'h4;
      end
      else if (i_valid && is_esc)
        esc_reg <= 1'b1;
      else if (i_valid && open_reg)
      begin
        data_reg <= plain;
        {valid_reg, had_reg, esc_reg} <= 3'h6;
      end
    end
  end
  assign o_data = data_reg;
  assign o_valid = valid_reg;
  assign o_end = end_reg;
endmodule

// ----------------------------------------------------------------
// Device end
// ----------------------------------------------------------------
// Function
// - packet port 115200 baud, transmit-side flow control only.
// - packets use HDLC framing, one stop, no parity.
// - receive-side handshake optional; reception works without it.
// - device asserts transmit request before any byte.
// - host drives transmit clear low when ready.
// - after clear seen, whole packet sent without pausing.
// - request released after packet, held off minimum gap.
// - host releases clear before packet end, waits interval.
// - text port two wires, fixed 9600 baud, 8N1.
// - ports idle low power, wake on activity.
// - host holds unused handshake inputs at inactive level.
// - text port pin pair chosen by external memory setting.
module scp_dev_end (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  scp_if.dev link,
  input wire logic i_ext_mem_en,
  input wire logic [7:0] i_pkt_data,
  input wire logic i_pkt_valid,
  input wire logic i_pkt_last,
  output logic o_pkt_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_end,
  input wire logic [7:0] i_txt_data,
  input wire logic i_txt_valid,
  output logic o_txt_ready,
  output logic [7:0] o_txt_data,
  output logic o_txt_valid,
  output logic o_awake
);
  logic from_host, clear_n, rx_req_n, txt_a, txt_b;
  logic [8:0] f_data;
  logic f_valid, f_ready, fr_busy, pkt_busy, txt_busy, txt_line;
  logic [7:0] pkt_byte;
  logic pkt_byte_valid;
  logic a_out_reg, b_out_reg, rx_clear_n_reg, awake_reg;
  scp_sync3 u_s_from (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_pin(link.pkt_from_host), .o_level(from_host));
  scp_sync3 u_s_clear (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_pin(link.transmit_side_clear_n), .o_level(clear_n));
  scp_sync3 u_s_rreq (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_pin(link.receive_side_request_n), .o_level(rx_req_n));
  scp_sync3 u_s_ta (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_pin(link.text_port_a_in), .o_level(txt_a));
  scp_sync3 u_s_tb (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_pin(link.text_port_b_in), .o_level(txt_b));
  // The FIFO lets the user queue a packet while the host still withholds clear.
  scp_fifo u_fifo (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_data({i_pkt_last, i_pkt_data}), .i_valid(i_pkt_valid), .o_ready(o_pkt_ready),
    .o_data(f_data), .o_valid(f_valid), .i_ready(f_ready));
  scp_framer u_framer (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_clear_n(clear_n), .i_gap(scp_pkg::TX_GAP_CYC), .i_data(f_data),
    .i_valid(f_valid), .o_ready(f_ready), .o_line(link.pkt_to_host),
    .o_req_n(link.transmit_side_request_n), .o_busy(fr_busy));
  scp_uart_rx u_prx (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_div(scp_pkg::PKT_DIV), .i_line(from_host), .o_data(pkt_byte),
    .o_valid(pkt_byte_valid), .o_busy(pkt_busy));
  scp_deframe u_deframe (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_byte(pkt_byte), .i_valid(pkt_byte_valid), .o_data(o_rx_data),
    .o_valid(o_rx_valid), .o_end(o_rx_end));
  wire logic txt_in = i_ext_mem_en ? txt_b : txt_a;
  scp_uart_rx u_trx (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_div(scp_pkg::TXT_DIV), .i_line(txt_in), .o_data(o_txt_data),
    .o_valid(o_txt_valid), .o_busy(txt_busy));
  scp_uart_tx u_ttx (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_div(scp_pkg::TXT_DIV), .i_data(i_txt_data), .i_valid(i_txt_valid),
    .o_ready(o_txt_ready), .o_line(txt_line));
  wire logic activity = fr_busy || f_valid || pkt_busy || txt_busy || !o_txt_ready ||
                        !from_host || !txt_in;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      a_out_reg <= scp_pkg::LINE_IDLE;
      b_out_reg <= scp_pkg::LINE_IDLE;
      rx_clear_n_reg <= 1'b1;
      awake_reg <= 1'b0;
    end
    else
    begin
      a_out_reg <= i_ext_mem_en ? scp_pkg::LINE_IDLE : txt_line;
      b_out_reg <= i_ext_mem_en ? txt_line : scp_pkg::LINE_IDLE;
      rx_clear_n_reg <= rx_req_n;
      awake_reg <= activity;
    end
  end
  assign link.text_port_a_out = a_out_reg;
  assign link.text_port_b_out = b_out_reg;
  assign link.receive_side_clear_n = rx_clear_n_reg;
  assign o_awake = awake_reg;
endmodule

`default_nettype wire

// [src/scp_host_end.sv]
// Host end of the serial command ports, built from the shared serial blocks.
// Assumes the device end file is compiled first.
`timescale 1ns/100ps
`default_nettype none

module scp_host_end (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  scp_if.host link,
  input wire logic i_ext_mem_en,
  input wire logic [7:0] i_pkt_data,
  input wire logic i_pkt_valid,
  input wire logic i_pkt_last,
  output logic o_pkt_ready,
  input wire logic i_host_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_end,
  input wire logic [7:0] i_txt_data,
  input wire logic i_txt_valid,
  output logic o_txt_ready,
  output logic [7:0] o_txt_data,
  output logic o_txt_valid
);
  logic to_host, txt_a, txt_b, rx_busy, txt_line;
  logic [8:0] f_data;
  logic f_valid, f_ready;
  logic [7:0] pkt_byte;
  logic pkt_byte_valid;
  logic clear_n_reg, recv_reg, a_in_reg, b_in_reg;
  logic [15:0] gap_reg;
  // The host needs no permission to send, so its sender sees a clear that is always low.
  wire logic always_clear_n = 1'b0;
  scp_sync3 u_s_to (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_pin(link.pkt_to_host), .o_level(to_host));
  scp_sync3 u_s_ta (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_pin(link.text_port_a_out), .o_level(txt_a));
  scp_sync3 u_s_tb (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_pin(link.text_port_b_out), .o_level(txt_b));
  scp_fifo u_fifo (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_data({i_pkt_last, i_pkt_data}), .i_valid(i_pkt_valid), .o_ready(o_pkt_ready),
    .o_data(f_data), .o_valid(f_valid), .i_ready(f_ready));
  scp_framer u_framer (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_clear_n(always_clear_n), .i_gap(scp_pkg::REQ_GAP_CYC), .i_data(f_data),
    .i_valid(f_valid), .o_ready(f_ready), .o_line(link.pkt_from_host),
    .o_req_n(link.receive_side_request_n), .o_busy());
  scp_uart_rx u_prx (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_div(scp_pkg::PKT_DIV), .i_line(to_host), .o_data(pkt_byte),
    .o_valid(pkt_byte_valid), .o_busy(rx_busy));
  scp_deframe u_deframe (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_byte(pkt_byte), .i_valid(pkt_byte_valid), .o_data(o_rx_data),
    .o_valid(o_rx_valid), .o_end(o_rx_end));
  wire logic txt_in = i_ext_mem_en ? txt_b : txt_a;
  scp_uart_rx u_trx (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_div(scp_pkg::TXT_DIV), .i_line(txt_in), .o_data(o_txt_data),
    .o_valid(o_txt_valid), .o_busy());
  scp_uart_tx u_ttx (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_div(scp_pkg::TXT_DIV), .i_data(i_txt_data), .i_valid(i_txt_valid),
    .o_ready(o_txt_ready), .o_line(txt_line));
  wire logic may_clear = i_host_ready && !recv_reg && !rx_busy && gap_reg == 16'h0000;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      clear_n_reg <= 1'b1;
      recv_reg <= 1'b0;
      gap_reg <= 16'h0000;
      a_in_reg <= scp_pkg::LINE_IDLE;
      b_in_reg <= scp_pkg::LINE_IDLE;
    end
    else
    begin
      clear_n_reg <= !may_clear;
      recv_reg <= o_rx_end ? 1'b0 : (recv_reg || rx_busy);
      if (o_rx_end)
        gap_reg <= scp_pkg::HOST_GAP_CYC;
      else if (gap_reg != 16'h0000)
        gap_reg <= gap_reg - 16'h0001;
      a_in_reg <= i_ext_mem_en ? scp_pkg::LINE_IDLE : txt_line;
      b_in_reg <= i_ext_mem_en ? txt_line : scp_pkg::LINE_IDLE;
    end
  end
  assign link.transmit_side_clear_n = clear_n_reg;
  assign link.text_port_a_in = a_in_reg;
  assign link.text_port_b_in = b_in_reg;
endmodule

`default_nettype wire

// [src/scp_if.sv]
// Wires joining the device end and the host end of the serial command ports.
// Assumes both ends run from their own copy of the same system clock.
`timescale 1ns/100ps
`default_nettype none

interface scp_if;
  logic pkt_to_host;
  logic pkt_from_host;
  logic transmit_side_request_n;
  logic transmit_side_clear_n;
  logic receive_side_request_n;
  logic receive_side_clear_n;
  logic text_port_a_in;
  logic text_port_a_out;
  logic text_port_b_in;
  logic text_port_b_out;

  modport dev (
    input pkt_from_host, transmit_side_clear_n, receive_side_request_n,
    input text_port_a_in, text_port_b_in,
    output pkt_to_host, transmit_side_request_n, receive_side_clear_n,
    output text_port_a_out, text_port_b_out
  );

  modport host (
    output pkt_from_host, transmit_side_clear_n, receive_side_request_n,
    output text_port_a_in, text_port_b_in,
    input pkt_to_host, transmit_side_request_n, receive_side_clear_n,
    input text_port_a_out, text_port_b_out
  );
endinterface

`default_nettype wire

// [src/scp_pkg.sv]
// Constants, types and helpers shared by both ends of the serial command ports.
// Assumes a single 25 MHz system clock on each end.
`default_nettype none

package scp_pkg;

  // ----------------------------------------------------------------
  // Clock and baud rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int PKT_BAUD = 115_200;
  localparam int TXT_BAUD = 9_600;
  localparam logic [15:0] PKT_DIV = 16'((CLK_HZ + PKT_BAUD / 2) / PKT_BAUD);
  localparam logic [15:0] TXT_DIV = 16'((CLK_HZ + TXT_BAUD / 2) / TXT_BAUD);

  // ----------------------------------------------------------------
  // Character and framing layout
  // ----------------------------------------------------------------
  localparam int DATA_BITS = 8;
  localparam logic [3:0] STOP_BIT_IDX = 4'h9;
  localparam logic [3:0] TX_DONE_IDX = 4'hA;
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int LAST_BIT_POS = 8;
  localparam logic [7:0] HDLC_FLAG = 8'h7E;
  localparam logic [7:0] HDLC_ESC = 8'h7D;
  localparam logic [7:0] HDLC_XOR = 8'h20;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic LINE_IDLE = 1'b1;
  localparam int TX_GAP_NS = 50_000;
  localparam logic [15:0] TX_GAP_CYC =
    16'((TX_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam int HOST_GAP_NS = 50_000;
  localparam logic [15:0] HOST_GAP_CYC =
    16'((HOST_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam logic [15:0] REQ_GAP_CYC = 16'h0001;

  // ----------------------------------------------------------------
  // Frame sender states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FR_IDLE = 3'b000,
    FR_REQ = 3'b001,
    FR_DATA = 3'b010,
    FR_ESC2 = 3'b011,
    FR_CLOSE = 3'b100,
    FR_DRAIN = 3'b101
  } scp_frame_type;

  function automatic logic is_special(input logic [7:0] b);
    is_special = (b == HDLC_FLAG) || (b == HDLC_ESC);
  endfunction

endpackage

`default_nettype wire

// [test/scp_monitor.sv]
// Checker on the link wires between the two ends.
// Assumes the testbench feeds it the link wires.
`timescale 1ns/100ps
`default_nettype none
module scp_monitor (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic pkt_to_host,
  input wire logic transmit_side_request_n,
  input wire logic transmit_side_clear_n,
  input wire logic receive_side_request_n,
  input wire logic receive_side_clear_n,
  input wire logic text_port_a_out,
  input wire logic text_port_b_out
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic t_idle;
  logic [15:0] gap_reg;
  logic [15:0] plo_reg;
  logic [15:0] tlo_reg;
  logic sending_reg;
  logic [15:0] hi_reg;
  assign t_idle = text_port_a_out & text_port_b_out;
  // The gap count saturates, so a long idle spell never wraps to a short one.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
    if (!i_resetn)
    begin
      gap_reg <= scp_pkg::TX_GAP_CYC;
      plo_reg <= 16'h0000;
      tlo_reg <= 16'h0000;
      sending_reg <= 1'b0;
      hi_reg <= 16'h0000;
    end
    else
    begin
      gap_reg <= transmit_side_request_n ? gap_reg + {15'h0000, ~&gap_reg} : 16'h0000;
      plo_reg <= pkt_to_host ? 16'h0000 : plo_reg + 16'h0001;
      tlo_reg <= t_idle ? 16'h0000 : tlo_reg + 16'h0001;
      sending_reg <= !transmit_side_request_n && (sending_reg || !pkt_to_host);
      hi_reg <= (sending_reg && pkt_to_host) ? hi_reg + 16'h0001 : 16'h0000;
    end
  req_first_a: assert property (!pkt_to_host |-> !transmit_side_request_n)
    else $error("line low unrequested");
  no_pause_a: assert property (hi_reg <= 16'h0960)
    else $error("paused");
  req_gap_a: assert property ($fell(transmit_side_request_n)
    |-> gap_reg >= scp_pkg::TX_GAP_CYC) else $error("gap short");
  clear_drop_a: assert property ($fell(pkt_to_host)
    |-> ##[1:12] transmit_side_clear_n) else $error("clear held");
  rx_echo_a: assert property ($fell(receive_side_request_n)
    |-> ##[1:8] !receive_side_clear_n) else $error("no echo");
  one_pair_a: assert property (text_port_a_out || text_port_b_out)
    else $error("two pairs");
  pkt_baud_a: assert property ($rose(pkt_to_host)
    |-> plo_reg % scp_pkg::PKT_DIV == 16'h0000) else $error("packet baud");
  txt_baud_a: assert property ($rose(t_idle)
    |-> tlo_reg % scp_pkg::TXT_DIV == 16'h0000) else $error("text baud");
  cover property ($fell(transmit_side_request_n));
  cover property ($fell(receive_side_request_n));
  cover property ($rose(t_idle));
endmodule
`default_nettype wire

// [test/test_api_and_cli_uart_ports.sv]
// Testbench joining the device end to the host end over one link.
// Assumes the design and checker files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_api_and_cli_uart_ports;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic ext = 1'b0;
  logic rdy = 1'b0;
  logic [1:0] pv = 2'b00;
  logic [1:0] pl = 2'b00;
  logic [1:0] tv = 2'b00;
  logic [15:0] pd = 16'h0000;
  logic [15:0] td = 16'h0000;
  wire [3:0] v;
  wire [31:0] d;
  wire [1:0] prdy, rxe, trdy;
  wire awake;
  int n_errors = 0;
  int check_count = 0;
  int ev = 0;
  int ne = 0;
  logic [7:0] eq[4][$];
  scp_if link ();
  scp_dev_end scp_dev_end_inst (.i_clk_sys, .i_resetn, .link, .i_ext_mem_en(ext),
    .i_pkt_data(pd[7:0]), .i_pkt_valid(pv[0]), .i_pkt_last(pl[0]), .o_pkt_ready(prdy[0]),
    .o_rx_data(d[7:0]), .o_rx_valid(v[0]), .o_rx_end(rxe[0]), .i_txt_data(td[7:0]),
    .i_txt_valid(tv[0]), .o_txt_ready(trdy[0]), .o_txt_data(d[23:16]), .o_txt_valid(v[2]),
    .o_awake(awake));
  scp_host_end scp_host_end_inst (.i_clk_sys, .i_resetn, .link, .i_ext_mem_en(ext),
    .i_pkt_data(pd[15:8]), .i_pkt_valid(pv[1]), .i_pkt_last(pl[1]), .o_pkt_ready(prdy[1]),
    .i_host_ready(rdy), .o_rx_data(d[15:8]), .o_rx_valid(v[1]), .o_rx_end(rxe[1]),
    .i_txt_data(td[15:8]), .i_txt_valid(tv[1]), .o_txt_ready(trdy[1]), .o_txt_data(d[31:24]),
    .o_txt_valid(v[3]));
  scp_monitor scp_monitor_inst (.i_clk_sys, .i_resetn, .pkt_to_host(link.pkt_to_host),
    .transmit_side_request_n(link.transmit_side_request_n),
    .transmit_side_clear_n(link.transmit_side_clear_n),
    .receive_side_request_n(link.receive_side_request_n),
    .receive_side_clear_n(link.receive_side_clear_n),
    .text_port_a_out(link.text_port_a_out), .text_port_b_out(link.text_port_b_out));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic pw(input int h, input logic [7:0] b, input logic l);
    @(posedge i_clk_sys);
    pd[h*8 +: 8] <= b;
    pl[h] <= l;
    pv[h] <= 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      @(posedge i_clk_sys);
      if (prdy[h] === 1'b1)
        break;
    end
    if (prdy[h] !== 1'b1)
    begin
      n_errors++;
      print_verdict();
    end
    pv[h] <= 1'b0;
  endtask
  task automatic ts(input logic [7:0] b);
    @(posedge i_clk_sys);
    td <= {b, b};
    tv <= 2'b11;
    @(posedge i_clk_sys);
    chk("txt_ready", 8'h03, {6'h00, trdy});
    tv <= 2'b00;
    @(posedge i_clk_sys);
    chk("txt_busy", 8'h00, {6'h00, trdy});
  endtask
  // A limit that runs out ends the run at once.
  task automatic wev(input int n);
    for (int k = 0; k < 30000 && ev < n; k++)
      @(posedge i_clk_sys);
    if (ev < n)
    begin
      n_errors++;
      print_verdict();
    end
    repeat (5208) @(posedge i_clk_sys);
  endtask
  always @(posedge i_clk_sys)
    for (int i = 0; i < 4; i++)
    begin
      if (v[i] === 1'b1)
      begin
        chk("byte", eq[i].pop_front(), d[i*8 +: 8]);
        ev++;
      end
      if (i < 2 && rxe[i % 2] === 1'b1)
        ne++;
    end
  initial
    forever #20 i_clk_sys = ~i_clk_sys;
  initial
  begin
    eq[0] = {8'h5A, 8'h7E};
    eq[1] = {8'h7E, 8'h7D, 8'h42, 8'h42};
    eq[2] = {8'hA5, 8'h3C};
    eq[3] = {8'hA5, 8'h3C};
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    ts(8'hA5);
    pw(0, 8'h7E, 1'b0);
    pw(0, 8'h7D, 1'b1);
    pw(0, 8'h42, 1'b1);
    repeat (2000) @(posedge i_clk_sys);
    chk("request_n", 8'h00, {7'h00, link.transmit_side_request_n});
    chk("line", 8'h01, {7'h00, link.pkt_to_host});
    chk("awake", 8'h01, {7'h00, awake});
    rdy <= 1'b1;
    wev(5);
    $display("test held packet done");
    ext <= 1'b1;
    ts(8'h3C);
    pw(0, 8'h42, 1'b1);
    pw(1, 8'h5A, 1'b0);
    pw(1, 8'h7E, 1'b1);
    wev(10);
    chk("idle", 8'h00, {7'h00, awake});
    chk("ends", 8'h04, 8'(ne));
    $display("test crossing traffic done");
    print_verdict();
  end
endmodule
`default_nettype wire
